//--- bench/modem_model.sv
// device model: registers, task engine and status flags of the modem
module modem_model
  import rx_seq_pkg::*;
(
  // clock
  input wire logic pclk,
  // modem port
  input wire logic dev_cs_n,
  input wire logic dev_wr_n,
  input wire logic dev_rd_n,
  input wire logic [DEV_AW-1:0] dev_addr,
  input wire logic [7:0] dev_data_o,
  output logic [7:0] dev_data_i,
  // events commanded by the bench
  input wire logic sync_in,
  input wire logic done_in,
  input wire logic crc_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mode_reg = 8'h00;
  logic [7:0] ctrl_reg = 8'h00;
  logic [7:0] byte_reg = 8'h30;
  logic [7:0] last_reg = 8'h00;
  logic [7:0] rd_val;
  logic auto_sync_detect_enable = 1'b0;
  logic auto_sync_detected_flag = 1'b0;
  logic block_buffer_free_flag = 1'b0;
  logic checksum_error_flag = 1'b0;
  logic task_running = 1'b0;
  logic wr_q = 1'b1;
  logic rd_q = 1'b1;
  logic [7:0] cmd_q[$];

  // read mux; a released bus toggles so stale bytes never pass
  always_comb begin
    rd_val = byte_reg;
    if (dev_addr == DEV_STAT) begin
      rd_val = 8'h00;
      rd_val[DSTAT_BUFFER_FREE] = block_buffer_free_flag;
      rd_val[DSTAT_AUTO_SYNC] = auto_sync_detected_flag;
      rd_val[DSTAT_CHECKSUM] = checksum_error_flag;
    end
  end
  assign dev_data_i = (!dev_cs_n && !dev_rd_n) ? rd_val : ~last_reg;

  // accesses end at strobe release; sync is applied last so it wins
  always @(posedge pclk) begin
    wr_q <= dev_wr_n;
    rd_q <= dev_rd_n;
    last_reg <= dev_data_i;
    if (!dev_cs_n && dev_rd_n && !rd_q) begin
      if (dev_addr == DEV_STAT) auto_sync_detected_flag <= 1'b0;
      if (dev_addr == DEV_DATA) byte_reg <= byte_reg + 8'h01;
    end
    if (!dev_cs_n && dev_wr_n && !wr_q) begin
      case (dev_addr)
        DEV_MODE: mode_reg <= dev_data_o;
        DEV_CTRL: ctrl_reg <= dev_data_o;
        DEV_CMD: begin
          cmd_q.push_back(dev_data_o);
          auto_sync_detect_enable <= dev_data_o[7];
          byte_reg <= 8'h30;
          if (dev_data_o[6:0] == TASK_RESET) begin
            block_buffer_free_flag <= 1'b1;
            auto_sync_detected_flag <= 1'b0;
            checksum_error_flag <= 1'b0;
            task_running <= 1'b0;
          end else if (dev_data_o[6:0] != TASK_NULL) begin
            block_buffer_free_flag <= 1'b0;
            task_running <= 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (done_in && task_running) begin
      block_buffer_free_flag <= 1'b1;
      checksum_error_flag <= crc_in;
      task_running <= 1'b0;
    end
    if (sync_in && auto_sync_detect_enable) begin
      auto_sync_detected_flag <= 1'b1;
      task_running <= 1'b0;
    end
  end
endmodule : modem_model

//--- bench/rx_seq_asserts.sv
// checker: port-level properties of the receive task sequencer
module rx_seq_asserts
  import rx_seq_pkg::*;
#(
  parameter logic [7:0] MODE_ALLOWED_MASK = 8'h07,
  parameter logic [7:0] CTRL_DIV_MASK = 8'h0f,
  parameter logic [7:0] CTRL_NARROW_BIT = 8'h10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb answer side
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // modem port
  input wire logic dev_cs_n,
  input wire logic dev_wr_n,
  input wire logic dev_rd_n,
  input wire logic [DEV_AW-1:0] dev_addr,
  input wire logic [7:0] dev_data_o,
  input wire logic dev_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // four strobe cycles, then one hold cycle before select lifts
  sequence wr_strobe;
    (!dev_wr_n)[*4] ##1 dev_wr_n ##1 dev_cs_n;
  endsequence : wr_strobe
  sequence rd_strobe;
    (!dev_rd_n)[*4] ##1 dev_rd_n ##1 dev_cs_n;
  endsequence : rd_strobe

  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  write_cycle_a: assert property ($fell(dev_wr_n) |-> !$past(dev_cs_n) ##0 wr_strobe)
    else $error("malformed modem write cycle");
  read_cycle_a: assert property ($fell(dev_rd_n) |-> !$past(dev_cs_n) ##0 rd_strobe)
    else $error("malformed modem read cycle");
  write_drive_a: assert property (!dev_wr_n |-> !dev_cs_n && dev_data_oe && dev_rd_n)
    else $error("write strobe without bus drive");
  read_release_a: assert property (!dev_rd_n |-> !dev_cs_n && !dev_data_oe)
    else $error("bus driven during a read");
  addr_stable_a: assert property (!dev_cs_n && !$past(dev_cs_n) |-> $stable(dev_addr) && $stable(dev_data_o))
    else $error("address or data moved under select");
  cmd_auto_a: assert property (!dev_wr_n && dev_addr == DEV_CMD |-> dev_data_o[7] || dev_data_o[6:0] == TASK_SYNC_SEARCH)
    else $error("command without auto detect");
  mode_bits_a: assert property (!dev_wr_n && dev_addr == DEV_MODE |-> (dev_data_o & ~MODE_ALLOWED_MASK) == 8'h00)
    else $error("forbidden mode bit written");
  ctrl_bits_a: assert property (!dev_wr_n && dev_addr == DEV_CTRL |->
    (dev_data_o & ~(CTRL_DIV_MASK | CTRL_NARROW_BIT)) == 8'h00 && (dev_data_o & CTRL_NARROW_BIT) != 8'h00)
    else $error("bad control byte written");
endmodule : rx_seq_asserts

//--- bench/tb_rx_task_sequencer.sv
// testbench: apb-driven receive sequences against the modem model
module tb_rx_task_sequencer
  import rx_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MODE_MASK = 8'h07;
  localparam logic [7:0] DIV_MASK = 8'h0f;
  localparam logic [7:0] NARROW_BIT = 8'h10;
  localparam logic [6:0] SID = 7'h01;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dev_cs_n, dev_wr_n, dev_rd_n, dev_data_oe, sync_in, done_in, crc_in;
  logic [DEV_AW-1:0] dev_addr;
  logic [7:0] dev_data_o, dev_data_i;
  int errors = 0;
  int num_checks = 0;

  rx_task_sequencer #(
    .BLOCK_BYTES(8), .MODE_ALLOWED_MASK(MODE_MASK), .CTRL_DIV_MASK(DIV_MASK), .CTRL_NARROW_BIT(NARROW_BIT),
    .SID_TASK(SID)
  ) i_rx_task_sequencer (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_cs_n(dev_cs_n),
    .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .dev_addr(dev_addr), .dev_data_o(dev_data_o),
    .dev_data_oe(dev_data_oe), .dev_data_i(dev_data_i)
  );
  modem_model i_modem_model (
    .pclk(pclk), .dev_cs_n(dev_cs_n), .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .dev_addr(dev_addr),
    .dev_data_o(dev_data_o), .dev_data_i(dev_data_i), .sync_in(sync_in), .done_in(done_in), .crc_in(crc_in)
  );

  // clock source
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; an idle cycle follows so psel never flips twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
  endtask : rd_chk

  // next command byte the modem received, waited for under a bound
  task automatic wait_cmd(input logic [7:0] exp);
    int n;
    n = 0;
    while (i_modem_model.cmd_q.size() == 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 2000) check("command", 32'hxxxxxxxx, 32'(exp));
    else check("command", 32'(i_modem_model.cmd_q.pop_front()), 32'(exp));
  endtask : wait_cmd

  task automatic pulse(input logic sync, input logic crc);
    crc_in <= crc;
    if (sync) sync_in <= 1'b1;
    else done_in <= 1'b1;
    @(posedge pclk);
    sync_in <= 1'b0;
    done_in <= 1'b0;
  endtask : pulse

  // block completes, controller reads it and moves on; flags judged, ready cleared
  task automatic blk(input logic crc, input logic [7:0] next, input logic exp_crc);
    logic [31:0] r;
    logic e;
    pulse(1'b0, crc);
    wait_cmd(next);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check("checksum flag", 32'(r[ST_CRC_ERR]), 32'(exp_crc));
    check("block ready", 32'(r[ST_BLOCK_READY]), 32'h1);
    wr(REG_STATUS, 32'h2);
  endtask : blk

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd_chk("status reset", REG_STATUS, 32'h0);
    rd_chk("mode reset", REG_MODE_CFG, 32'(MODE_CFG_RST));
    rd_chk("ctrl reset", REG_CTRL_CFG, 32'(CTRL_CFG_RST));
    rd_chk("blocks reset", REG_BLOCKS, 32'(BLOCKS_RST));
    apb(1'b0, 8'h20, 32'h0, r, e);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
    wr(REG_MODE_CFG, 32'hff);
    wr(REG_CTRL_CFG, 32'hff);
    wr(REG_BLOCKS, 32'h3);
    rd_chk("blocks", REG_BLOCKS, 32'h3);
    $display("test regs done");
  endtask : t_regs

  task automatic t_msg;
    wr(REG_CTRL, 32'h1);
    wait_cmd(8'h87);
    check("mode byte", 32'(i_modem_model.mode_reg), 32'(8'hff & MODE_MASK));
    check("ctrl byte", 32'(i_modem_model.ctrl_reg), 32'((8'hff & DIV_MASK) | NARROW_BIT));
    pulse(1'b1, 1'b0);
    wait_cmd(8'h82);
    blk(1'b1, 8'h83, 1'b1);
    rd_chk("first byte", 8'h40, 32'h30);
    rd_chk("last byte", 8'h5c, 32'h37);
    blk(1'b0, 8'h83, 1'b1);
    blk(1'b0, 8'h80, 1'b0);
    pulse(1'b1, 1'b0);
    wait_cmd(8'h82);
    pulse(1'b1, 1'b0);
    wait_cmd(8'h82);
    $display("test message done");
  endtask : t_msg

  task automatic t_high;
    logic [31:0] r;
    logic e;
    wr(REG_CTRL, 32'h2);
    wait_cmd(8'h80);
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      if (r[ST_BUSY] === 1'b0) break;
    end
    check("idle after stop", 32'(r[ST_BUSY]), 32'h0);
    wr(REG_BLOCKS, 32'h2);
    wr(REG_CTRL, 32'hd);
    wait_cmd(8'h87);
    pulse(1'b1, 1'b0);
    wait_cmd({AUTO_DETECT_ON, SID});
    pulse(1'b0, 1'b0);
    wait_cmd(8'h82);
    pulse(1'b0, 1'b0);
    wait_cmd(8'h04);
    pulse(1'b0, 1'b0);
    wait_cmd({AUTO_DETECT_ON, SID});
    $display("test high rate done");
  endtask : t_high

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sync_in, done_in, crc_in} = '0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_msg;
    t_high;
    give_verdict;
  end

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict;
  end
endmodule : tb_rx_task_sequencer

bind rx_task_sequencer rx_seq_asserts #(
  .MODE_ALLOWED_MASK(MODE_ALLOWED_MASK), .CTRL_DIV_MASK(CTRL_DIV_MASK), .CTRL_NARROW_BIT(CTRL_NARROW_BIT)
) i_rx_seq_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .dev_cs_n(dev_cs_n), .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n), .dev_addr(dev_addr),
  .dev_data_o(dev_data_o), .dev_data_oe(dev_data_oe)
);

//--- hw/dev_port.sv
// module: strobed parallel access to the modem's registers
module dev_port
  import rx_seq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // request side
  input wire dev_req_t req,
  output dev_rsp_t rsp,
  // device pins
  output dev_pins_t pins,
  input wire logic [7:0] dev_data_i
);

  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_SETUP = 4'b0010,
    P_STROBE = 4'b0100,
    P_HOLD = 4'b1000
  } port_st_t;

  typedef struct packed {
    port_st_t st;
    logic [3:0] cnt;
    logic [7:0] sync1;
    logic [7:0] sync2;
    dev_pins_t pins;
    dev_rsp_t rsp;
  } port_t;

  port_t r_reg;
  port_t r_next;

  assign pins = r_reg.pins;
  assign rsp = r_reg.rsp;

  // access sequencer: setup, strobe, hold
  always_comb begin
    r_next = r_reg;
    r_next.sync1 = dev_data_i;
    r_next.sync2 = r_reg.sync1;
    r_next.rsp.done = 1'b0;
    unique case (r_reg.st)
      P_IDLE: begin
        // skip the cycle of done so a held request is not taken twice
        if (req.valid && !r_reg.rsp.done) begin
          r_next.pins.cs_n = 1'b0;
          r_next.pins.addr = req.addr;
          r_next.pins.data_o = req.wdata;
          r_next.pins.data_oe = req.write;
          r_next.st = P_SETUP;
        end
      end
      P_SETUP: begin
        r_next.pins.wr_n = !req.write;
        r_next.pins.rd_n = req.write;
        r_next.cnt = STROBE_CYC - 4'h1;
        r_next.st = P_STROBE;
      end
      P_STROBE: begin
        if (r_reg.cnt == 4'h0) begin
          // synced copy lags the pin by two edges, strobe covers that
          r_next.rsp.rdata = r_reg.sync2;
          r_next.pins.wr_n = 1'b1;
          r_next.pins.rd_n = 1'b1;
          r_next.st = P_HOLD;
        end else begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end
      end
      P_HOLD: begin
        r_next.pins.cs_n = 1'b1;
        r_next.pins.data_oe = 1'b0;
        r_next.rsp.done = 1'b1;
        r_next.st = P_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{st: P_IDLE, cnt: 4'h0, sync1: 8'h00, sync2: 8'h00,
                 pins: '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, data_o: 8'h00, data_oe: 1'b0},
                 rsp: '{done: 1'b0, rdata: 8'h00}};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

endmodule : dev_port

//--- hw/rx_seq_pkg.sv
// package: constants and carriers for the receive task sequencer
// Behaviour
// - mode register gets only permitted bits
// - control gets divider, narrow-rate bit, rest zero
// - reception starts with command 87h
// - first sync found by autonomous detector
// - after sync, issue header task 82h
// - autonomous detect stays on during block tasks
// - wait for sync-detected or buffer-free flag
// - sync-detected means restart at header task
// - buffer-free alone means block ready, read it
// - check checksum only after header or last
// - continue with 82h or 83h, then wait
// - done with message: write 80h, await sync
// - concatenated, no reuse: may use search 04h
// - high-rate mode: first block is station id
package rx_seq_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE_CFG = 8'h08;
  localparam logic [7:0] REG_CTRL_CFG = 8'h0c;
  localparam logic [7:0] REG_BLOCKS = 8'h10;
  localparam logic [7:0] REG_DEV_STAT = 8'h14;
  localparam logic [1:0] DATA_WINDOW = 2'b01; // paddr[7:6], bytes at 0x40 + 4*i

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_HIGH_RATE = 2;
  localparam int CTRL_SFS_OK = 3;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_BLOCK_READY = 1;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_SYNCED = 3;
  localparam int ST_BLK_LSB = 8;
  localparam int ST_SYNC_CNT_LSB = 16;

  // reset values
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] CTRL_CFG_RST = 8'h00;
  localparam logic [7:0] BLOCKS_RST = 8'h01;

  // device register addresses on its parallel port
  localparam int DEV_AW = 3;
  localparam logic [DEV_AW-1:0] DEV_MODE = 3'h0;
  localparam logic [DEV_AW-1:0] DEV_CTRL = 3'h1;
  localparam logic [DEV_AW-1:0] DEV_CMD = 3'h2;
  localparam logic [DEV_AW-1:0] DEV_STAT = 3'h3;
  localparam logic [DEV_AW-1:0] DEV_DATA = 3'h4;

  // command byte: top bit autonomous detect, low bits task code
  localparam logic AUTO_DETECT_ON = 1'b1;
  localparam logic [6:0] TASK_NULL = 7'h00;
  localparam logic [6:0] TASK_RESET = 7'h07;
  localparam logic [6:0] TASK_HEADER = 7'h02;
  localparam logic [6:0] TASK_INTER_LAST = 7'h03;
  localparam logic [6:0] TASK_SYNC_SEARCH = 7'h04;

  // device status bit positions
  localparam int DSTAT_BUFFER_FREE = 6;
  localparam int DSTAT_AUTO_SYNC = 5;
  localparam int DSTAT_CHECKSUM = 3;

  // pin strobe timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // one device register access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [DEV_AW-1:0] addr;
    logic [7:0] wdata;
  } dev_req_t;

  // answer to a device access
  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } dev_rsp_t;

  // driven device pins
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [DEV_AW-1:0] addr;
    logic [7:0] data_o;
    logic data_oe;
  } dev_pins_t;

endpackage : rx_seq_pkg

//--- hw/rx_task_sequencer.sv
// module: apb-controlled receive task sequencer driving the modem
//
// Design decisions made here: the APB slave port and the register addresses.
module rx_task_sequencer
  import rx_seq_pkg::*;
#(
  parameter int BLOCK_BYTES = 8,
  parameter logic [7:0] MODE_ALLOWED_MASK = 8'h07,
  parameter logic [7:0] CTRL_DIV_MASK = 8'h0f,
  parameter logic [7:0] CTRL_NARROW_BIT = 8'h10,
  parameter logic [6:0] SID_TASK = 7'h01
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modem parallel port
  output logic dev_cs_n,
  output logic dev_wr_n,
  output logic dev_rd_n,
  output logic [DEV_AW-1:0] dev_addr,
  output logic [7:0] dev_data_o,
  output logic dev_data_oe,
  input wire logic [7:0] dev_data_i
);

  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_MODE = 10'b0000000010,
    S_CTRL = 10'b0000000100,
    S_START = 10'b0000001000,
    S_POLL_SYNC = 10'b0000010000,
    S_ISSUE = 10'b0000100000,
    S_POLL_BLK = 10'b0001000000,
    S_READ = 10'b0010000000,
    S_DONE_BLK = 10'b0100000000,
    S_END = 10'b1000000000
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic start_req;
    logic stop_req;
    logic high_rate;
    logic sfs_ok;
    logic [7:0] mode_cfg;
    logic [7:0] ctrl_cfg;
    logic [7:0] blocks_wanted;
    logic block_ready;
    logic crc_err;
    logic synced;
    logic sfs_wait;
    logic [7:0] blk_idx;
    logic [7:0] sync_cnt;
    logic [7:0] last_stat;
    logic [7:0] byte_idx;
    logic [BLOCK_BYTES-1:0][7:0] rx_bytes;
    dev_req_t req;
  } seq_t;

  seq_t r_reg;
  seq_t r_next;
  dev_rsp_t rsp;
  dev_pins_t pins;

  // build a device access request
  function automatic dev_req_t dev_op(input logic wr, input logic [DEV_AW-1:0] a, input logic [7:0] d);
    dev_req_t q;
    q.valid = 1'b1;
    q.write = wr;
    q.addr = a;
    q.wdata = d;
    return q;
  endfunction : dev_op

  // compose a command byte from the detect enable and a task code
  function automatic logic [7:0] cmd_byte(input logic auto_on, input logic [6:0] task_code);
    return {auto_on, task_code};
  endfunction : cmd_byte

  // apb read mux; unmapped addresses read zero
  function automatic logic [31:0] reg_read(input seq_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[7:6] == DATA_WINDOW) begin
      if (int'(a[5:2]) < BLOCK_BYTES) begin
        d[7:0] = s.rx_bytes[a[5:2]];
      end
    end else begin
      unique case (a)
        REG_CTRL: begin
          d[CTRL_HIGH_RATE] = s.high_rate;
          d[CTRL_SFS_OK] = s.sfs_ok;
        end
        REG_STATUS: begin
          d[ST_BUSY] = (s.st != S_IDLE);
          d[ST_BLOCK_READY] = s.block_ready;
          d[ST_CRC_ERR] = s.crc_err;
          d[ST_SYNCED] = s.synced;
          d[ST_BLK_LSB +: 8] = s.blk_idx;
          d[ST_SYNC_CNT_LSB +: 8] = s.sync_cnt;
        end
        REG_MODE_CFG: d[7:0] = s.mode_cfg;
        REG_CTRL_CFG: d[7:0] = s.ctrl_cfg;
        REG_BLOCKS: d[7:0] = s.blocks_wanted;
        REG_DEV_STAT: d[7:0] = s.last_stat;
        default: d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction : reg_read

  // true for a mapped apb address
  function automatic logic reg_hit(input logic [7:0] a);
    logic h;
    h = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_MODE_CFG) || (a == REG_CTRL_CFG) ||
        (a == REG_BLOCKS) || (a == REG_DEV_STAT);
    if (a[7:6] == DATA_WINDOW) begin
      h = int'(a[5:2]) < BLOCK_BYTES;
    end
    return h;
  endfunction : reg_hit

  dev_port i_dev_port (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .req(r_reg.req),
    .rsp(rsp),
    .pins(pins),
    .dev_data_i(dev_data_i)
  );

  // outputs straight from flops
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign dev_cs_n = pins.cs_n;
  assign dev_wr_n = pins.wr_n;
  assign dev_rd_n = pins.rd_n;
  assign dev_addr = pins.addr;
  assign dev_data_o = pins.data_o;
  assign dev_data_oe = pins.data_oe;

  // apb slave and task sequencer
  always_comb begin
    logic access;
    logic commit;
    logic auto_sync;
    logic buf_free;
    logic first_blk;
    logic last_blk;
    logic [7:0] hdr_idx;
    logic [6:0] task_code;
    access = psel && penable && !r_reg.pready;
    commit = psel && penable && r_reg.pready;
    auto_sync = rsp.rdata[DSTAT_AUTO_SYNC];
    buf_free = rsp.rdata[DSTAT_BUFFER_FREE];
    hdr_idx = r_reg.high_rate ? 8'h01 : 8'h00;
    first_blk = (r_reg.blk_idx == 8'h00);
    last_blk = (r_reg.blk_idx + 8'h01 >= r_reg.blocks_wanted);
    r_next = r_reg;
    r_next.pready = access;
    // error flag stands only beside pready
    r_next.pslverr = 1'b0;
    if (access) begin
      r_next.prdata = pwrite ? 32'h0000_0000 : reg_read(r_reg, paddr);
      r_next.pslverr = !reg_hit(paddr);
    end

    // register writes take effect only at the completing edge
    if (commit && pwrite) begin
      unique case (paddr)
        REG_CTRL: begin
          if (pwdata[CTRL_START] && r_reg.st == S_IDLE) begin
            r_next.start_req = 1'b1;
          end
          if (pwdata[CTRL_STOP] && r_reg.st != S_IDLE) begin
            r_next.stop_req = 1'b1;
          end
          r_next.high_rate = pwdata[CTRL_HIGH_RATE];
          r_next.sfs_ok = pwdata[CTRL_SFS_OK];
        end
        REG_STATUS: begin
          if (pwdata[ST_BLOCK_READY]) begin
            r_next.block_ready = 1'b0;
          end
        end
        REG_MODE_CFG: r_next.mode_cfg = pwdata[7:0];
        REG_CTRL_CFG: r_next.ctrl_cfg = pwdata[7:0];
        REG_BLOCKS: r_next.blocks_wanted = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        default: ;
      endcase
    end

    // released on the edge that returns the answer
    if (rsp.done) begin
      r_next.req.valid = 1'b0;
    end

    // task code for the next block of the message
    if (r_reg.high_rate && first_blk) begin
      task_code = SID_TASK;
    end else if (r_reg.blk_idx == hdr_idx) begin
      task_code = TASK_HEADER;
    end else begin
      task_code = TASK_INTER_LAST;
    end

    unique case (r_reg.st)
      S_IDLE: begin
        if (r_reg.start_req) begin
          r_next.start_req = 1'b0;
          r_next.synced = 1'b0;
          r_next.blk_idx = 8'h00;
          r_next.st = S_MODE;
        end
      end
      S_MODE: begin
        if (!r_reg.req.valid) begin
          r_next.req = dev_op(1'b1, DEV_MODE, r_reg.mode_cfg & MODE_ALLOWED_MASK);
        end
        if (rsp.done) begin
          r_next.st = S_CTRL;
        end
      end
      S_CTRL: begin
        if (!r_reg.req.valid) begin
          r_next.req = dev_op(1'b1, DEV_CTRL, (r_reg.ctrl_cfg & CTRL_DIV_MASK) | CTRL_NARROW_BIT);
        end
        if (rsp.done) begin
          r_next.st = S_START;
        end
      end
      S_START: begin
        // first sync always by the autonomous detector, never a search task
        if (!r_reg.req.valid) begin
          r_next.req = dev_op(1'b1, DEV_CMD, cmd_byte(AUTO_DETECT_ON, TASK_RESET));
        end
        if (rsp.done) begin
          r_next.sfs_wait = 1'b0;
          r_next.st = S_POLL_SYNC;
        end
      end
      S_POLL_SYNC: begin
        if (!r_reg.req.valid && !rsp.done) begin
          r_next.req = dev_op(1'b0, DEV_STAT, 8'h00);
        end
        if (rsp.done) begin
          // one read per poll: the sync flag clears on that read
          r_next.last_stat = rsp.rdata;
          if (r_reg.sfs_wait ? buf_free : auto_sync) begin
            r_next.synced = 1'b1;
            r_next.blk_idx = 8'h00;
            r_next.sync_cnt = r_reg.sync_cnt + 8'h01;
            r_next.st = S_ISSUE;
          end else if (r_reg.stop_req) begin
            r_next.st = S_END;
          end
        end
      end
      S_ISSUE: begin
        // a command already on the port is finished before stopping
        if (r_reg.stop_req && !r_reg.req.valid) begin
          r_next.st = S_END;
        end else begin
          if (!r_reg.req.valid) begin
            r_next.req = dev_op(1'b1, DEV_CMD, cmd_byte(AUTO_DETECT_ON, task_code));
          end
          if (rsp.done) begin
            r_next.st = S_POLL_BLK;
          end
        end
      end
      S_POLL_BLK: begin
        if (!r_reg.req.valid && !rsp.done) begin
          r_next.req = dev_op(1'b0, DEV_STAT, 8'h00);
        end
        if (rsp.done) begin
          r_next.last_stat = rsp.rdata;
          if (auto_sync) begin
            // new sync aborted the task: start the new message over
            r_next.blk_idx = 8'h00;
            r_next.sync_cnt = r_reg.sync_cnt + 8'h01;
            r_next.st = r_reg.stop_req ? S_END : S_ISSUE;
          end else if (buf_free) begin
            r_next.byte_idx = 8'h00;
            r_next.st = S_READ;
          end else if (r_reg.stop_req) begin
            r_next.st = S_END;
          end
        end
      end
      S_READ: begin
        if (!r_reg.req.valid && !rsp.done) begin
          r_next.req = dev_op(1'b0, DEV_DATA, 8'h00);
        end
        if (rsp.done) begin
          r_next.rx_bytes[r_reg.byte_idx[$clog2(BLOCK_BYTES)-1:0]] = rsp.rdata;
          r_next.byte_idx = r_reg.byte_idx + 8'h01;
          if (r_reg.byte_idx == 8'(BLOCK_BYTES - 1)) begin
            r_next.st = S_DONE_BLK;
          end
        end
      end
      S_DONE_BLK: begin
        // intermediate blocks carry no checksum, so the flag is left alone
        if (r_reg.blk_idx == hdr_idx || last_blk) begin
          r_next.crc_err = r_reg.last_stat[DSTAT_CHECKSUM];
        end
        r_next.block_ready = 1'b1;
        r_next.blk_idx = r_reg.blk_idx + 8'h01;
        r_next.st = (last_blk || r_reg.stop_req) ? S_END : S_ISSUE;
      end
      S_END: begin
        if (!r_reg.req.valid) begin
          if (r_reg.sfs_ok && r_reg.synced && !r_reg.stop_req) begin
            r_next.req = dev_op(1'b1, DEV_CMD, cmd_byte(1'b0, TASK_SYNC_SEARCH));
          end else begin
            r_next.req = dev_op(1'b1, DEV_CMD, cmd_byte(AUTO_DETECT_ON, TASK_NULL));
          end
        end
        if (rsp.done) begin
          r_next.sfs_wait = !r_reg.req.wdata[7];
          r_next.stop_req = 1'b0;
          r_next.st = r_reg.stop_req ? S_IDLE : S_POLL_SYNC;
        end
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{st: S_IDLE, prdata: 32'h0000_0000, mode_cfg: MODE_CFG_RST, ctrl_cfg: CTRL_CFG_RST,
                 blocks_wanted: BLOCKS_RST, blk_idx: 8'h00, sync_cnt: 8'h00, last_stat: 8'h00,
                 byte_idx: 8'h00, rx_bytes: '0, req: '0, default: 1'b0};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

endmodule : rx_task_sequencer
